// File: padop_pkg.sv
package padop_pkg;
  // ************************************************************
  // widths
  // ************************************************************
  localparam int DATA_W = 16;
  localparam int IN_W   = 17;
  localparam int DIFF_W = 18;

  // ************************************************************
  // codes
  // ************************************************************
  localparam logic [DATA_W-1:0] POS_FS_CODE = 16'h7FFF;
  localparam logic [DATA_W-1:0] NEG_FS_CODE = 16'h8000;
  localparam logic [DATA_W-1:0] MID_CODE    = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST    = 16'h0000;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int LATENCY_CYC   = 13;
  localparam int SETTLE_CYC    = 13;
  localparam logic [3:0] SETTLE_LAST = 4'hD;
endpackage

// File: padop_buf2.sv
`timescale 1ns/1ps
module padop_buf2
  import padop_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [DATA_W-1:0] in_data,
  input  wire logic              in_valid,
  output logic                   in_ready,
  output logic      [DATA_W-1:0] out_data,
  output logic                   out_valid,
  input  wire logic              out_ready
);
  logic [DATA_W-1:0] mem_reg [0:1];
  logic              rd_ptr_reg;
  logic              wr_ptr_reg;
  logic [1:0]        count_reg;
  logic              push;
  logic              pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_reg[0] <= DATA_RST;
      mem_reg[1] <= DATA_RST;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= 2'h0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 2'h1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 2'h1;
    end
  end
endmodule

// File: padop_core.sv
// Function
// - each result is a 16-bit signed word, a sign bit plus fifteen two's-complement value bits.
// - below negative full scale the output is the negative full-scale code.
// - above positive full scale the output is the positive full-scale code.
// - one new output word every conversion clock cycle.
// - the input is sampled on the falling clock edge.
// - a result appears on the thirteenth rising clock edge after its falling sampling edge.
// - during reset or calibration the data outputs are not results.
// - sign bit low for positive difference, high for negative difference.
// - zero difference converts to the all-zero mid-scale word.
// - output words are two's complement.
// - conversion-valid output is low while valid data is on the lines.
// - data drivers enabled while read strobe low, released while high.
// - outputs stay irrelevant for fourteen cycles after reset or calibration.
`timescale 1ns/1ps
module padop_core
  import padop_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              cal,
  input  wire logic [IN_W-1:0]   analog_in_pos,
  input  wire logic [IN_W-1:0]   analog_in_neg,
  input  wire logic              rd_n,
  output logic      [DATA_W-1:0] result_bus_o,
  output logic                   result_bus_oe,
  output logic                   eoc_n,
  output logic      [DATA_W-1:0] stream_data,
  output logic                   stream_valid,
  input  wire logic              stream_ready,
  output logic                   overflow
);
  // ************************************************************
  // sampling and saturation
  // ************************************************************
  logic signed [DIFF_W-1:0] diff;
  logic        [DATA_W-1:0] sat_code;
  logic        [DATA_W-1:0] samp_reg;
  logic        [DATA_W-1:0] pipe_reg [0:LATENCY_CYC-1];
  logic        [3:0]        settle_reg;
  logic                     eoc_n_reg;
  logic                     buf_in_ready;

  assign diff = DIFF_W'($signed(analog_in_pos)) - DIFF_W'($signed(analog_in_neg));

  always_comb begin
    if (diff > DIFF_W'($signed(POS_FS_CODE))) begin
      sat_code = POS_FS_CODE;
    end else if (diff < DIFF_W'($signed(NEG_FS_CODE))) begin
      sat_code = NEG_FS_CODE;
    end else begin
      sat_code = diff[DATA_W-1:0];
    end
  end

  always_ff @(negedge clk or negedge resetn) begin
    if (!resetn) begin
      samp_reg <= DATA_RST;
    end else begin
      samp_reg <= sat_code;
    end
  end

  // ************************************************************
  // pipeline
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < LATENCY_CYC; g++) begin : g_pipe
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pipe_reg[g] <= DATA_RST;
        end else if (g == 0) begin
          pipe_reg[g] <= samp_reg;
        end else begin
          pipe_reg[g] <= pipe_reg[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate

  assign result_bus_o  = pipe_reg[LATENCY_CYC-1];
  assign result_bus_oe = !rd_n;

  // ************************************************************
  // valid tracking
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle_reg <= 4'h0;
    end else if (cal) begin
      settle_reg <= 4'h0;
    end else if (settle_reg != SETTLE_LAST) begin
      settle_reg <= settle_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eoc_n_reg <= 1'b1;
    end else begin
      eoc_n_reg <= !((settle_reg == SETTLE_LAST) && !cal);
    end
  end

  assign eoc_n = eoc_n_reg;

  // ************************************************************
  // output buffer
  // ************************************************************
  padop_buf2 u_buf (
    .clk       (clk),
    .resetn    (resetn),
    .in_data   (result_bus_o),
    .in_valid  (!eoc_n_reg),
    .in_ready  (buf_in_ready),
    .out_data  (stream_data),
    .out_valid (stream_valid),
    .out_ready (stream_ready)
  );

  assign overflow = !eoc_n_reg && !buf_in_ready;

  // ************************************************************
  // settle watch
  // ************************************************************
  // edges since reset or calibration ended, saturating
  logic [3:0] quiet_cnt_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quiet_cnt_reg <= 4'h0;
    end else if (cal) begin
      quiet_cnt_reg <= 4'h0;
    end else if (quiet_cnt_reg != SETTLE_LAST) begin
      quiet_cnt_reg <= quiet_cnt_reg + 4'h1;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_oe;
    @(posedge clk) disable iff (!resetn) result_bus_oe == !rd_n;
  endproperty
  a_oe: assert property (p_oe) else $error("drive enable not following read strobe");

  property p_latency;
    @(posedge clk) disable iff (!resetn)
      !eoc_n |-> (result_bus_o == $past(samp_reg, LATENCY_CYC));
  endproperty
  a_latency: assert property (p_latency) else $error("result latency wrong");

  property p_neg_sat;
    @(negedge clk) disable iff (!resetn)
      (diff < -18'sd32768) |=> (samp_reg == 16'h8000);
  endproperty
  a_neg_sat: assert property (p_neg_sat) else $error("negative saturation wrong");

  property p_pos_sat;
    @(negedge clk) disable iff (!resetn)
      (diff > 18'sd32767) |=> (samp_reg == 16'h7FFF);
  endproperty
  a_pos_sat: assert property (p_pos_sat) else $error("positive saturation wrong");

  property p_mid;
    @(negedge clk) disable iff (!resetn) (diff == 18'sd0) |=> (samp_reg == 16'h0000);
  endproperty
  a_mid: assert property (p_mid) else $error("zero input not mid code");

  property p_sign;
    @(negedge clk) disable iff (!resetn)
      (diff != 18'sd0) |=> (samp_reg[15] == $past(diff[17]));
  endproperty
  a_sign: assert property (p_sign) else $error("sign bit wrong");

  property p_settle;
    @(posedge clk) disable iff (!resetn) $fell(cal) |-> eoc_n[*8];
  endproperty
  a_settle: assert property (p_settle) else $error("valid too soon after calibration");

  property p_valid;
    @(posedge clk) disable iff (!resetn)
      (settle_reg == SETTLE_LAST && !cal) |=> !eoc_n;
  endproperty
  a_valid: assert property (p_valid) else $error("valid not shown after settle");

  property p_cal_invalid;
    @(posedge clk) disable iff (!resetn) cal |=> eoc_n;
  endproperty
  a_cal_invalid: assert property (p_cal_invalid) else $error("valid during calibration");

  property p_quiet;
    @(posedge clk) disable iff (!resetn) (quiet_cnt_reg != SETTLE_LAST) |=> eoc_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("valid during settle time");

  // ************************************************************
  // stream checks
  // ************************************************************
  property p_stream_hold;
    @(posedge clk) disable iff (!resetn)
      (stream_valid && !stream_ready) |=> (stream_valid && $stable(stream_data));
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("head moved in stall");

  property p_word_step;
    @(posedge clk) disable iff (!resetn) !eoc_n |=> stream_valid;
  endproperty
  a_word_step: assert property (p_word_step) else $error("valid word not buffered");

  property p_ovf_stall;
    @(posedge clk) disable iff (!resetn) overflow |-> $past(!stream_ready);
  endproperty
  a_ovf_stall: assert property (p_ovf_stall) else $error("drop without stall");
endmodule

// File: padop_host.sv
`timescale 1ns/1ps
module padop_host
  import padop_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              stall,
  input  wire logic [DATA_W-1:0] stream_data,
  input  wire logic              stream_valid,
  output logic                   stream_ready,
  output logic      [DATA_W-1:0] last_word,
  output logic                   got
);
  // sink refuses words while stalled
  assign stream_ready = !stall;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_word <= DATA_RST;
      got       <= 1'b0;
    end else begin
      got <= stream_valid && stream_ready;
      if (stream_valid && stream_ready) begin
        last_word <= stream_data;
      end
    end
  end
endmodule

// File: padop_core_test.sv
`timescale 1ns/1ps
module padop_core_test;
  import padop_pkg::*;
  logic              clk = 0;
  logic              resetn = 0;
  logic              cal = 0;
  logic              rd_n = 1;
  logic              stall = 0;
  logic [IN_W-1:0]   pos = '0;
  logic [IN_W-1:0]   neg = '0;
  logic [DATA_W-1:0] bus_o, s_data, h_word, last_exp;
  logic              oe, eoc_n, s_valid, s_ready, ovf, got, ovf_seen;
  int                fails = 0;
  int                total_checks = 0;
  int                cyc = 0;

  always #5 clk = ~clk;

  padop_core i_dut (.clk(clk), .resetn(resetn), .cal(cal), .analog_in_pos(pos),
    .analog_in_neg(neg), .rd_n(rd_n), .result_bus_o(bus_o), .result_bus_oe(oe),
    .eoc_n(eoc_n), .stream_data(s_data), .stream_valid(s_valid),
    .stream_ready(s_ready), .overflow(ovf));
  padop_host i_host (.clk(clk), .resetn(resetn), .stall(stall), .stream_data(s_data),
    .stream_valid(s_valid), .stream_ready(s_ready), .last_word(h_word), .got(got));

  // ************************************************************
  // checks
  // ************************************************************
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_code(input logic [IN_W-1:0] p, input logic [IN_W-1:0] n,
                        input logic [DATA_W-1:0] exp);
    @(negedge clk);
    pos <= p;
    neg <= n;
    repeat (13) @(negedge clk);
    check("word before latency", last_exp, bus_o);
    @(negedge clk);
    check("word", exp, bus_o);
    check("valid flag", 16'h0000, 16'(eoc_n));
    last_exp = exp;
  endtask

  task automatic t_rd();
    @(negedge clk);
    rd_n <= 1'b0;
    @(negedge clk);
    check("drive on", 16'h0001, 16'(oe));
    rd_n <= 1'b1;
    @(negedge clk);
    check("drive off", 16'h0000, 16'(oe));
  endtask

  task automatic t_stream();
    repeat (3) @(negedge clk);
    check("host word", last_exp, h_word);
    check("host took", 16'h0001, 16'(got));
    check("stream valid", 16'h0001, 16'(s_valid));
    stall <= 1'b1;
    ovf_seen = 1'b0;
    repeat (5) begin
      @(negedge clk);
      ovf_seen = ovf_seen | ovf;
    end
    check("dropped pulse", 16'h0001, 16'(ovf_seen));
    check("held head", last_exp, s_data);
    stall <= 1'b0;
    repeat (2) @(negedge clk);
    check("drained", 16'h0001, 16'(got));
  endtask

  task automatic t_cal();
    @(negedge clk);
    cal <= 1'b1;
    repeat (2) @(negedge clk);
    check("valid in cal", 16'h0001, 16'(eoc_n));
    cal <= 1'b0;
    repeat (13) @(negedge clk);
    check("valid settling", 16'h0001, 16'(eoc_n));
    repeat (2) @(negedge clk);
    check("valid settled", 16'h0000, 16'(eoc_n));
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    last_exp = MID_CODE;
    repeat (8) @(negedge clk);
    check("drive in reset", 16'h0000, 16'(oe));
    resetn <= 1'b1;
    repeat (16) @(negedge clk);
    t_code(17'h00000, 17'h00000, MID_CODE);
    t_code(17'h00005, 17'h00000, 16'h0005);
    t_code(17'h00000, 17'h00005, 16'hFFFB);
    t_code(17'h07FFF, 17'h00000, POS_FS_CODE);
    t_code(17'h08000, 17'h00000, POS_FS_CODE);
    t_code(17'h00000, 17'h08000, NEG_FS_CODE);
    t_code(17'h10000, 17'h0FFFF, NEG_FS_CODE);
    t_code(17'h0FFFF, 17'h10000, POS_FS_CODE);
    t_rd();
    t_stream();
    t_cal();
    give_verdict();
  end
endmodule
